// [core/qte_fifo.sv]
`timescale 1ns/100ps
module qte_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // draining side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  import qte_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [CW-1:0]    count_q, count_d;
  logic             ready_q, ready_d;
  logic             push, pop;

  // pointer and fill bookkeeping
  always_comb begin
    push    = inValid & ready_q;
    pop     = outReady & (count_q != '0);
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
    ready_d = (count_d != CW'(DEPTH));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      ready_q <= ready_d;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  assign inReady  = ready_q;
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];

endmodule : qte_fifo

// [core/qte_pkg.sv]
package qte_pkg;

  // widths and depths
  localparam int          DATA_W      = 8;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          SCR_W       = 33;

  // scrambler feedback taps, one per configuration plus one shared
  localparam int          MASTER_TAP  = 12;
  localparam int          SLAVE_TAP   = 19;
  localparam int          LAST_TAP    = 32;
  localparam logic [32:0] SCR_SEED    = 33'h1_5a5a_c3a5;

  // octet that marks carrier extension outside a frame
  localparam logic [7:0]  EXT_OCTET   = 8'h0f;

  // periods for which an extension error persists after the first reset
  localparam logic [1:0]  EXT_ERR_HOLD = 2'h3;

  // core clock cycles per symbol period
  localparam int          SYM_DIV     = 1;

  // transmit mode from the link control
  typedef enum logic [1:0] {
    MODE_SEND_Z,
    MODE_SEND_I,
    MODE_SEND_N
  } qte_mode_t;

  // which row group the symbol mapper must use
  typedef enum logic [3:0] {
    KIND_ZERO,
    KIND_IDLE,
    KIND_NORMAL,
    KIND_XMT_ERR,
    KIND_CSRESET,
    KIND_CSEXT,
    KIND_CSEXT_ERR,
    KIND_SSD1,
    KIND_SSD2,
    KIND_ESD_EXT_ERR
  } qte_kind_t;

  // one octet from the mac side
  typedef struct packed {
    logic [7:0] data;
    logic       frameActive;
    logic       txErr;
  } qte_gmii_t;

  // one coded symbol period
  typedef struct packed {
    qte_kind_t  kind;
    logic [2:0] column;
    logic [5:0] row;
    logic [8:0] encodedWord;
  } qte_sym_t;

endpackage : qte_pkg

// [core/qte_scrambler.sv]
`timescale 1ns/100ps
module qte_scrambler (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       advance,
  input  wire logic       isMaster,
  // derived words
  output logic      [3:0] xWord,
  output logic      [3:0] yWord
);
  import qte_pkg::*;

  logic [SCR_W-1:0] scr_q, scr_d;
  logic             newBit;

  // one bit per symbol period, taps chosen by configuration
  always_comb begin
    newBit = (isMaster ? scr_q[MASTER_TAP] : scr_q[SLAVE_TAP])
             ^ scr_q[LAST_TAP];
    scr_d  = advance ? {scr_q[SCR_W-2:0], newBit} : scr_q;
  end

  // seed is non-zero so the sequence never locks up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scr_q <= SCR_SEED;
    end else begin
      scr_q <= scr_d;
    end
  end

  // words taken from the delay line
  always_comb begin
    yWord[0] = scr_q[0];
    yWord[1] = scr_q[3] ^ scr_q[8];
    yWord[2] = scr_q[6] ^ scr_q[16];
    yWord[3] = scr_q[9] ^ scr_q[14] ^ scr_q[19] ^ scr_q[24];
    xWord[0] = scr_q[4] ^ scr_q[6];
    xWord[1] = scr_q[7] ^ scr_q[9] ^ scr_q[12] ^ scr_q[14];
    xWord[2] = scr_q[10] ^ scr_q[12] ^ scr_q[20] ^ scr_q[22];
    xWord[3] = scr_q[13] ^ scr_q[15] ^ scr_q[18] ^ scr_q[20]
               ^ scr_q[30];
  end

endmodule : qte_scrambler

// [core/qte_tx_encoder.sv]
// Notes on behaviour
// - scrambler octet scrambles data and forms quartets
// - octet high nibble is x word when active
// - low nibble zero, y word, or inverted previous
// - encoded bits 5..3 scramble data when active
// - three-bit convolutional state feeds encoded bit 8
// - state zero outside data; reset flag at end
// - bits 7..6 data, old state, or scrambler
// - bit 2 carries receiver status outside data
// - extension flags from error and octet value
// - bits 1..0 carry extension flags outside data
// - word splits into column and row
// - error in frame substitutes error symbols
// - encoder reset without error uses reset symbols
// - reset with error uses extension symbols
// - extension error persists through end periods
// - first two preamble octets become start delimiter
// - first delimiter when active, previously inactive
// - second delimiter one period after first
// - scrambler polynomial depends on master or slave
// - scrambler seed is never all zeros
`timescale 1ns/100ps
module qte_tx_encoder #(
  parameter int FIFO_DEPTH_P = qte_pkg::FIFO_DEPTH,
  parameter int SYM_DIV_P    = qte_pkg::SYM_DIV
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // mac side octet stream
  input  wire qte_pkg::qte_gmii_t  inWord,
  input  wire logic                inValid,
  output logic                     inReady,
  // link control
  input  wire qte_pkg::qte_mode_t  txMode,
  input  wire logic                isMaster,
  input  wire logic                locRcvrOk,
  // coded symbol stream
  output qte_pkg::qte_sym_t        symOut,
  output logic                     symValid
);
  import qte_pkg::*;

  localparam int GW = $bits(qte_gmii_t);
  localparam int DW = $clog2(SYM_DIV_P + 1);

  // fifo to encoder
  qte_gmii_t  cur;
  logic [GW-1:0] fifoData;
  logic       fifoValid;
  logic       step;

  // divider state
  logic [DW-1:0] divCnt_q, divCnt_d;
  logic          tick_q, tick_d;

  // history and encoder state
  logic [3:0] enHist_q, enHist_d;
  logic [3:0] erHist_q, erHist_d;
  logic [3:1] prevY_q, prevY_d;
  logic [2:0] cs_q, cs_d;
  logic       parity_q, parity_d;
  logic [1:0] errHold_q, errHold_d;

  // output registers
  qte_sym_t   sym_q, sym_d;
  logic       symValid_q, symValid_d;

  // scrambler words
  logic [3:0] xWord, yWord;

  // combinational encoder values
  logic [7:0] scramblerOctet;
  logic [8:0] encodedWord;
  logic       en, en1, en2, er;
  logic       csReset, cext, cextErr, isExtOctet;
  qte_kind_t  kind;

  // input buffer; back-pressure reaches the mac through inReady
  qte_fifo #(
    .WIDTH (GW),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inData   (inWord),
    .inValid  (inValid),
    .inReady  (inReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (step)
  );

  // side-stream scrambler, stepped once per symbol period
  qte_scrambler u_scr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .advance  (step),
    .isMaster (isMaster),
    .xWord    (xWord),
    .yWord    (yWord)
  );

  // symbol period divider
  always_comb begin
    if (divCnt_q == DW'(SYM_DIV_P - 1)) begin
      divCnt_d = '0;
      tick_d   = 1'b1;
    end else begin
      divCnt_d = divCnt_q + 1'b1;
      tick_d   = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= '0;
      tick_q   <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      tick_q   <= tick_d;
    end
  end

  // a period runs only when the mac has an octet ready
  assign step = tick_q & fifoValid;
  assign cur  = qte_gmii_t'(fifoData);

  // current and delayed qualifiers
  always_comb begin
    en  = cur.frameActive;
    er  = cur.txErr;
    en1 = enHist_q[0];
    en2 = enHist_q[1];
    isExtOctet = (cur.data == EXT_OCTET);
    csReset    = en2 & ~en;
    cext       = er & ~en & isExtOctet;
    cextErr    = er & ~en & ~isExtOctet;
  end

  // scrambler octet
  always_comb begin
    scramblerOctet[7:4] = en2 ? xWord : 4'h0;
    if (txMode == MODE_SEND_Z) begin
      scramblerOctet[3:0] = 4'h0;
    end else begin
      scramblerOctet[0]   = yWord[0];
      scramblerOctet[3:1] = parity_q ? ~prevY_q : yWord[3:1];
    end
  end

  // encoded word and convolutional state
  always_comb begin
    if (en2 && !csReset) begin
      encodedWord[7:6] = scramblerOctet[7:6] ^ cur.data[7:6];
    end else if (csReset) begin
      encodedWord[7:6] = cs_q[1:0];
    end else begin
      encodedWord[7:6] = scramblerOctet[7:6];
    end
    encodedWord[5:3] = en2 ? scramblerOctet[5:3] ^ cur.data[5:3]
                           : scramblerOctet[5:3];
    if (en2) begin
      encodedWord[2:0] = scramblerOctet[2:0] ^ cur.data[2:0];
    end else begin
      encodedWord[2] = scramblerOctet[2] ^ locRcvrOk;
      encodedWord[1] = scramblerOctet[1] ^ cextErr;
      encodedWord[0] = scramblerOctet[0] ^ cext;
    end
    cs_d[0] = cs_q[2];
    cs_d[1] = en2 ? encodedWord[6] ^ cs_q[0] : 1'b0;
    cs_d[2] = en2 ? encodedWord[7] ^ cs_q[1] : 1'b0;
    encodedWord[8] = cs_d[0];
  end

  // substitution choice, strongest first
  always_comb begin
    errHold_d = errHold_q;
    if (step && errHold_q != 2'h0) begin
      errHold_d = errHold_q - 2'h1;
    end
    if (txMode == MODE_SEND_Z) begin
      kind = KIND_ZERO;
    end else if (txMode == MODE_SEND_I) begin
      kind = KIND_IDLE;
    end else if (csReset) begin
      if (errHold_q != 2'h0 || (er && !isExtOctet)) begin
        kind = KIND_CSEXT_ERR;
      end else if (!er) begin
        kind = KIND_CSRESET;
      end else begin
        kind = KIND_CSEXT;
      end
      // a fresh extension error restarts the hold over any count in flight
      if (step && en1 && er && !isExtOctet) begin
        errHold_d = EXT_ERR_HOLD;
      end
    end else if (en && en2) begin
      kind = er ? KIND_XMT_ERR : KIND_NORMAL;
    end else if (en && !en1) begin
      kind = KIND_SSD1;
    end else if (en1 && !en2) begin
      kind = KIND_SSD2;
    end else if (errHold_q != 2'h0) begin
      kind = KIND_ESD_EXT_ERR;
    end else begin
      kind = KIND_IDLE;
    end
  end

  // next state per symbol period
  always_comb begin
    enHist_d   = enHist_q;
    erHist_d   = erHist_q;
    prevY_d    = prevY_q;
    parity_d   = parity_q;
    sym_d      = sym_q;
    symValid_d = step;
    if (step) begin
      enHist_d = {enHist_q[2:0], en};
      erHist_d = {erHist_q[2:0], er};
      prevY_d  = yWord[3:1];
      parity_d = ~parity_q;
      sym_d.kind        = kind;
      sym_d.encodedWord = encodedWord;
      sym_d.column      = {encodedWord[6], encodedWord[7],
                           encodedWord[8]};
      sym_d.row         = encodedWord[5:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enHist_q   <= 4'h0;
      erHist_q   <= 4'h0;
      prevY_q    <= 3'h0;
      cs_q       <= 3'h0;
      parity_q   <= 1'b0;
      errHold_q  <= 2'h0;
      sym_q      <= '0;
      symValid_q <= 1'b0;
    end else begin
      enHist_q   <= enHist_d;
      erHist_q   <= erHist_d;
      prevY_q    <= prevY_d;
      if (step) begin
        cs_q <= cs_d;
      end
      parity_q   <= parity_d;
      errHold_q  <= errHold_d;
      sym_q      <= sym_d;
      symValid_q <= symValid_d;
    end
  end

  assign symOut   = sym_q;
  assign symValid = symValid_q;

  // checks on the coding path
  chk_sc_high_nibble: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step |-> scramblerOctet[7:4] == (en2 ? xWord : 4'h0))
    else $error("scrambler octet high nibble wrong");

  chk_sc_odd_invert: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && parity_q && txMode != MODE_SEND_Z
      |-> scramblerOctet[3:1] == ~prevY_q)
    else $error("odd period nibble not inverted");

  chk_cs_idle_zero: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && !en2 && !enHist_q[2] |=> cs_q == 3'h0)
    else $error("encoder state not cleared outside data");

  chk_word_bit8: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step |=> symValid && symOut.encodedWord[8] == cs_q[0])
    else $error("encoded bit 8 differs from state bit 0");

  chk_csreset_kind: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && txMode == MODE_SEND_N && csReset && !er
      && errHold_q == 2'h0 |=> symOut.kind == KIND_CSRESET)
    else $error("encoder reset symbols missing");

  chk_err_subst: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && txMode == MODE_SEND_N && en && en2 && er
      |=> symOut.kind == KIND_XMT_ERR)
    else $error("error symbols missing inside frame");

  chk_ssd_first: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && txMode == MODE_SEND_N && en && !en1 && !en2
      |=> symOut.kind == KIND_SSD1)
    else $error("first start delimiter missing");

  chk_ext_err_hold: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && txMode == MODE_SEND_N && csReset && en1 && er
      && !isExtOctet && errHold_q == 2'h0
      |=> errHold_q == EXT_ERR_HOLD ##1 errHold_q != 2'h0)
    else $error("extension error not held");

  chk_ssd_second: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && txMode == MODE_SEND_N && en1 && !en2
      |=> symOut.kind == KIND_SSD2)
    else $error("second start delimiter missing");

  chk_zero_nibble: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && txMode == MODE_SEND_Z |-> scramblerOctet[3:0] == 4'h0)
    else $error("send zero nibble not cleared");

  chk_bit2_status: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && !en2 |=> symOut.encodedWord[2]
      == ($past(scramblerOctet[2]) ^ $past(locRcvrOk)))
    else $error("receiver status bit wrong");

  chk_ext_low_bits: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && !en2 |=> symOut.encodedWord[1:0]
      == ($past(scramblerOctet[1:0]) ^ {$past(cextErr), $past(cext)}))
    else $error("extension bits wrong outside data");

  chk_reset_bits: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    step && csReset |=> symOut.encodedWord[7:6] == $past(cs_q[1:0]))
    else $error("reset bits not old state");

endmodule : qte_tx_encoder

// [dv/qte_mac_model.sv]
`timescale 1ns/100ps
module qte_mac_model
  import qte_pkg::*;
(
  // clock
  input  wire logic core_clk,
  // octet stream towards the encoder
  output qte_gmii_t inWord,
  output logic      inValid,
  input  wire logic inReady
);
  qte_gmii_t sendQ[$];
  qte_gmii_t lastW;
  int        gapPct;

  // queue one octet for a later symbol period
  task automatic push(input qte_gmii_t w);
    sendQ.push_back(w);
  endtask : push

  // quiet bus at time zero
  initial begin
    inValid = 1'b0;
    inWord  = '0;
    lastW   = '0;
    gapPct  = 0;
  end

  // offer the head octet and hold it until taken; a released bus shows junk
  always @(posedge core_clk) begin
    if (!(inValid && !inReady)) begin
      if (inValid) void'(sendQ.pop_front());
      if (sendQ.size() != 0 && ($urandom % 100) >= gapPct) begin
        inValid <= 1'b1;
        inWord  <= sendQ[0];
        lastW    = sendQ[0];
      end else begin
        inValid <= 1'b0;
        inWord  <= ~lastW;
      end
    end
  end
endmodule : qte_mac_model

// [dv/qte_tx_encoder_tb.sv]
`timescale 1ns/100ps
module qte_tx_encoder_tb;
  import qte_pkg::*;
  typedef struct packed {
    qte_gmii_t w;
    qte_mode_t m;
    logic      ok;
  } qte_take_t;

  logic        core_clk, rst_n, inValid, inReady, isMaster, locRcvrOk;
  logic        symValid;
  qte_gmii_t   inWord;
  qte_mode_t   txMode;
  qte_sym_t    symOut, expSym;
  qte_take_t   takeQ[$];
  int          n_fail, check_count, refused;
  // reference state of the encoder
  logic [32:0] scr;
  logic [3:0]  prevY;
  logic [2:0]  cs;
  logic [1:0]  hold;
  logic        par, en1, en2;
  logic [9:0]  corner[12] = '{10'h000, 10'h296, 10'h0f3, 10'h206, 10'h109,
    10'h000, 10'h000, 10'h000, 10'h1fa, 10'h03d, 10'h03d, 10'h000};

  qte_mac_model mac (.core_clk(core_clk), .inWord(inWord),
    .inValid(inValid), .inReady(inReady));
  qte_tx_encoder #(.SYM_DIV_P(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .inWord(inWord), .inValid(inValid), .inReady(inReady), .txMode(txMode),
    .isMaster(isMaster), .locRcvrOk(locRcvrOk), .symOut(symOut),
    .symValid(symValid));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // one symbol period of the reference encoder
  function automatic qte_sym_t refStep(input qte_take_t r);
    logic [3:0] x, y;
    logic [7:0] sc, d;
    logic [8:0] sd;
    logic [2:0] csN;
    logic       en, er, csr, cext, cerr;
    qte_sym_t   e;
    d  = r.w.data;
    en = r.w.frameActive;
    er = r.w.txErr;
    y  = {scr[9]^scr[14]^scr[19]^scr[24], scr[6]^scr[16],
          scr[3]^scr[8], scr[0]};
    x  = {scr[13]^scr[15]^scr[18]^scr[20]^scr[30],
          scr[10]^scr[12]^scr[20]^scr[22], scr[7]^scr[9]^scr[12]^scr[14],
          scr[4]^scr[6]};
    sc[7:4] = en2 ? x : 4'h0;
    sc[3:0] = (r.m == MODE_SEND_Z) ? 4'h0
            : {par ? ~prevY[3:1] : y[3:1], y[0]};
    csr  = en2 & ~en;
    cext = er & ~en & (d == EXT_OCTET);
    cerr = er & ~en & (d != EXT_OCTET);
    sd[5:3] = en2 ? sc[5:3] ^ d[5:3] : sc[5:3];
    sd[7:6] = csr ? cs[1:0] : (en2 ? sc[7:6] ^ d[7:6] : sc[7:6]);
    sd[2]   = en2 ? sc[2] ^ d[2] : sc[2] ^ r.ok;
    sd[1:0] = en2 ? sc[1:0] ^ d[1:0] : sc[1:0] ^ {cerr, cext};
    csN = {en2 & (sd[7] ^ cs[1]), en2 & (sd[6] ^ cs[0]), cs[2]};
    sd[8] = csN[0];
    if (r.m == MODE_SEND_Z) e.kind = KIND_ZERO;
    else if (r.m == MODE_SEND_I) e.kind = KIND_IDLE;
    else if (csr) e.kind = (hold != 0 || cerr) ? KIND_CSEXT_ERR :
      (cext ? KIND_CSEXT : KIND_CSRESET);
    else if (en & en2) e.kind = er ? KIND_XMT_ERR : KIND_NORMAL;
    else if (en & ~en1) e.kind = KIND_SSD1;
    else if (en1 & ~en2) e.kind = KIND_SSD2;
    else if (hold != 0) e.kind = KIND_ESD_EXT_ERR;
    else e.kind = KIND_IDLE;
    e.encodedWord = sd;
    e.column = {sd[6], sd[7], sd[8]};
    e.row = sd[5:0];
    hold = (csr & en1 & cerr) ? EXT_ERR_HOLD
         : (hold != 0 ? hold - 2'h1 : 2'h0);
    prevY = y;
    cs = csN;
    par = ~par;
    en2 = en1;
    en1 = en;
    scr = {scr[31:0],
           scr[isMaster ? MASTER_TAP : SLAVE_TAP] ^ scr[LAST_TAP]};
    return e;
  endfunction : refStep

  // record accepted octets and compare each coded symbol
  always @(posedge core_clk) begin
    if (rst_n) begin
      if (inValid && !inReady) refused++;
      if (inValid && inReady)
        takeQ.push_back(qte_take_t'{inWord, txMode, locRcvrOk});
      if (symValid === 1'b1) begin
        if (takeQ.size() == 0)
          check(32'h1, 32'h0, "symbol without octet");
        else begin
          expSym = refStep(takeQ.pop_front());
          check(symOut.encodedWord, expSym.encodedWord,
                "word");
          check(symOut.kind, expSym.kind, "kind");
          check({symOut.column, symOut.row},
                {expSym.column, expSym.row}, "map");
        end
      end
    end
  end

  // reset with reference restart and reset values
  task automatic doReset;
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(inReady, 1'b1, "reset ready");
    check(symValid, 1'b0, "reset valid");
    check(symOut, 32'h0, "reset symbol");
    takeQ.delete();
    scr = SCR_SEED;
    {prevY, cs, hold, par, en1, en2} = '0;
    rst_n <= 1'b1;
  endtask : doReset

  task automatic drain;
    int k;
    k = 0;
    // inValid covers the edge where the model has popped but not yet logged
    while ((mac.sendQ.size() != 0 || takeQ.size() != 0 || inValid)
           && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 4000) begin
      check(32'h1, 32'h0, "drain timeout");
      test_done();
    end
  endtask : drain

  // random frames with idle gaps, closed by clean idle
  task automatic runSeg(input qte_mode_t m, input logic ms, input int nf);
    qte_gmii_t w;
    @(posedge core_clk);
    txMode    <= m;
    isMaster  <= ms;
    locRcvrOk <= 1'($urandom);
    for (int f = 0; f < nf; f++) begin
      for (int i = 0; i < 1 + $urandom % 8; i++) begin
        w = {8'($urandom), 1'b1, (m == MODE_SEND_N) && ($urandom % 6 == 0)};
        mac.push(w);
      end
      for (int i = 0; i < 1 + $urandom % 5; i++) begin
        w = {($urandom % 2) ? EXT_OCTET : 8'($urandom), 1'b0,
             (m == MODE_SEND_N) && ($urandom % 3 == 0)};
        mac.push(w);
      end
    end
    for (int i = 0; i < 4; i++) mac.push('0);
    drain();
  endtask : runSeg

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    check(32'h1, 32'h0, "run timeout");
    test_done();
  end

  // main sequence: every mode in both scrambler set-ups, corners, fifo fill
  initial begin
    rst_n = 1'b0;
    txMode = MODE_SEND_I;
    isMaster = 1'b1;
    locRcvrOk = 1'b1;
    {n_fail, check_count, refused} = '0;
    void'($urandom(97));
    doReset();
    mac.gapPct = 40;
    for (int m = 0; m < 3; m++) begin
      runSeg(qte_mode_t'(m), 1'b1, 6);
      runSeg(qte_mode_t'(m), 1'b0, 6);
    end
    foreach (corner[i]) mac.push(corner[i]);
    runSeg(MODE_SEND_N, 1'b1, 20);
    doReset();
    mac.gapPct = 0;
    runSeg(MODE_SEND_N, 1'b0, 10);
    check(refused != 0, 32'h1, "fifo never full");
    test_done();
  end
endmodule : qte_tx_encoder_tb
